// >>> adc_serial_defines.svh
// timing counts, field layouts and default values of the serial converter
`ifndef ADC_SERIAL_DEFINES_SVH
`define ADC_SERIAL_DEFINES_SVH

// ****************************************
// converter clock and timing
// ****************************************
`define CORE_CLK_PERIOD_NS 25
`define ACQUISITION_NS 1120
`define CONVERSION_DURATION_NS 8960
`define RESULT_BITS 10
`define ACQUISITION_CYCLES ((`ACQUISITION_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define STEP_CYCLES \
	((`CONVERSION_DURATION_NS + `CORE_CLK_PERIOD_NS * `RESULT_BITS - 1) / \
	(`CORE_CLK_PERIOD_NS * `RESULT_BITS))
`define COUNT_BITS 9

// ****************************************
// address byte and data byte layout
// ****************************************
`define ADDR_SELECT_DEFAULT 3'h5
`define DEVICE_CODE_MSB 7
`define DEVICE_CODE_LSB 4
`define ADDR_SELECT_MSB 3
`define ADDR_SELECT_LSB 1
`define DIR_BIT 0
`define DIR_READ 1'h1
`define HIGH_BYTE_PAD 4'h0
`define LOW_BYTE_PAD 2'h0
`define BITS_PER_BYTE 4'h8

`endif

// >>> adc_serial_pkg.sv
// types shared by the serial link and the converter core
package adc_serial_pkg;

	typedef struct packed {
		logic scl;
		logic sda;
	} pin_pair_t;

	typedef enum logic [2:0] {
		LINK_IGNORE,
		LINK_ADDR,
		LINK_ADDR_ACK,
		LINK_TX,
		LINK_TX_ACK
	} link_state_t;

	typedef struct packed {
		pin_pair_t pins_s1;
		pin_pair_t pins_s2;
		pin_pair_t pins_d;
		logic done_s1;
		logic done_s2;
		logic done_d;
		logic [9:0] latest;
		logic [9:0] held;
		link_state_t state;
		logic [3:0] bit_count;
		logic [7:0] shift;
		logic dir_read;
		logic low_byte;
		logic master_ack;
		logic sda_oen;
		logic conv_tgl;
	} link_regs_t;

	typedef enum logic [1:0] {
		CONV_IDLE,
		CONV_ACQUIRE,
		CONV_RUN
	} conv_state_t;

	typedef struct packed {
		logic req_s1;
		logic req_s2;
		logic req_seen;
		logic [9:0] ain_s1;
		logic [9:0] ain_s2;
		conv_state_t state;
		logic [8:0] count;
		logic [9:0] sample;
		logic [9:0] trial;
		logic [9:0] bit_mask;
		logic [9:0] result;
		logic done_tgl;
	} conv_regs_t;

endpackage

// >>> adc_conv_engine.sv
// self-timed sample, hold and successive approximation core
`timescale 1ns/1ps
`default_nettype none
`include "adc_serial_defines.svh"

module adc_conv_engine
	import adc_serial_pkg::*;
#(
	parameter int RESULT_W = `RESULT_BITS
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic start_tgl_in,
	input wire logic [RESULT_W-1:0] analog_input_pin_in,
	output logic [RESULT_W-1:0] result_out,
	output logic done_tgl_out,
	output logic busy_out
);

	localparam logic [8:0] ACQ_CYCLES = 9'(`ACQUISITION_CYCLES);
	localparam logic [8:0] STEP_CYCLES = 9'(`STEP_CYCLES);

	generate
		if (RESULT_W != `RESULT_BITS) begin : g_bad_width
			$error("result width must match the two byte layout");
		end
	endgenerate

	conv_regs_t r;
	conv_regs_t next_r;

	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		next_r = r;
		next_r.req_s1 = start_tgl_in;
		next_r.req_s2 = r.req_s1;
		next_r.ain_s1 = analog_input_pin_in;
		next_r.ain_s2 = r.ain_s1;
		unique case (r.state)
			CONV_IDLE: begin
				if (r.req_s2 != r.req_seen) begin
					next_r.req_seen = r.req_s2;
					next_r.count = ACQ_CYCLES; // RULE11
					next_r.state = CONV_ACQUIRE;
				end
			end
			CONV_ACQUIRE: begin
				next_r.count = r.count - 9'h001;
				if (r.count == 9'h001) begin
					next_r.sample = r.ain_s2;
					next_r.trial = 10'h200;
					next_r.bit_mask = 10'h200;
					next_r.count = STEP_CYCLES;
					next_r.state = CONV_RUN; // RULE24
				end
			end
			CONV_RUN: begin
				next_r.count = r.count - 9'h001;
				if (r.count == 9'h001) begin
					next_r.count = STEP_CYCLES;
					if (r.sample < r.trial) begin
						next_r.trial = r.trial & ~r.bit_mask;
					end
					next_r.bit_mask = r.bit_mask >> 1;
					next_r.trial = ((r.sample < r.trial) ? (r.trial & ~r.bit_mask) : r.trial)
						| (r.bit_mask >> 1);
					if (r.bit_mask == 10'h001) begin
						next_r.result = (r.sample < r.trial) ? (r.trial & ~r.bit_mask) : r.trial; // RULE22
						next_r.done_tgl = ~r.done_tgl;
						next_r.state = CONV_IDLE;
					end
				end
			end
			default: begin
				next_r.state = CONV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign result_out = r.result;
	assign done_tgl_out = r.done_tgl;
	assign busy_out = (r.state != CONV_IDLE);

endmodule
`default_nettype wire

// >>> adc_i2c_read_slave.sv
// two-wire read slave of the converter, link logic and core hook-up
// What this block does
// RULE1 - detect data falling while clock high
// RULE2 - detect data rising while clock high
// RULE3 - change data only while clock low
// RULE4 - master starts only on idle bus
// RULE5 - receiver acknowledges each byte on ninth pulse; code acks only the address byte, bytes after a write address get no ack
// RULE6 - master nak ends read, data released
// RULE7 - first byte: device code plus select bits
// RULE8 - select bits default to binary 101
// RULE9 - last address bit: one read, zero write
// RULE10 - write address acknowledged, no conversion
// RULE11 - read address launches self-timed conversion
// RULE12 - acknowledge address during the ninth pulse
// RULE13 - master releases data during address ack
// RULE14 - first byte: four zeros, top four bits
// RULE15 - master acknowledges first data byte
// RULE16 - second byte: six low bits, two spare
// RULE17 - master nak after second byte ends read
// RULE18 - next sample at last low-byte bit fall
// RULE19 - no limit on bytes between start, stop
// RULE20 - master ends exchange with a stop
// RULE21 - acked second byte repeats another conversion
// RULE22 - result held in ten-bit register
// RULE23 - result sent most significant bit first
// RULE24 - conversion timed by own clock
// RULE25 - foreign address ignored until next start
`timescale 1ns/1ps
`default_nettype none
`include "adc_serial_defines.svh"

module adc_i2c_read_slave
	import adc_serial_pkg::*;
#(
	parameter logic [3:0] DEVICE_CODE = 4'h6, // arbitrary value
	parameter logic [2:0] ADDR_SELECT = `ADDR_SELECT_DEFAULT, // RULE8
	parameter int RESULT_W = `RESULT_BITS
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic link_clk_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oen_out,
	input wire logic [RESULT_W-1:0] analog_input_pin_in,
	output logic [RESULT_W-1:0] result_out,
	output logic busy_out
);

	generate
		if (RESULT_W != `RESULT_BITS) begin : g_bad_width
			$error("result width must match the two byte layout");
		end
	endgenerate

	// ****************************************
	// byte builders
	// ****************************************
	function automatic logic [7:0] high_byte(input logic [9:0] res);
		high_byte = {`HIGH_BYTE_PAD, res[9:6]}; // RULE14
	endfunction

	function automatic logic [7:0] low_byte_of(input logic [9:0] res);
		low_byte_of = {res[5:0], `LOW_BYTE_PAD}; // RULE16
	endfunction

	// ****************************************
	// link reset release
	// ****************************************
	logic link_rst_s1;
	logic link_rstn;

	always_ff @(posedge link_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			link_rst_s1 <= 1'b0;
			link_rstn <= 1'b0;
		end else begin
			link_rst_s1 <= 1'b1;
			link_rstn <= link_rst_s1;
		end
	end

	// ****************************************
	// converter core
	// ****************************************
	logic [RESULT_W-1:0] core_result;
	logic core_done_tgl;

	link_regs_t r;
	link_regs_t next_r;

	adc_conv_engine #(
		.RESULT_W(RESULT_W)
	) u_conv (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.start_tgl_in(r.conv_tgl),
		.analog_input_pin_in(analog_input_pin_in),
		.result_out(core_result),
		.done_tgl_out(core_done_tgl),
		.busy_out(busy_out)
	);

	assign result_out = core_result;

	// ****************************************
	// bus events
	// ****************************************
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic addr_match;

	always_comb begin
		scl_rise = r.pins_s2.scl & ~r.pins_d.scl;
		scl_fall = ~r.pins_s2.scl & r.pins_d.scl;
		start_seen = r.pins_s2.scl & r.pins_d.scl & r.pins_d.sda & ~r.pins_s2.sda; // RULE1
		stop_seen = r.pins_s2.scl & r.pins_d.scl & ~r.pins_d.sda & r.pins_s2.sda; // RULE2
		addr_match = (r.shift[`DEVICE_CODE_MSB:`DEVICE_CODE_LSB] == DEVICE_CODE)
			&& (r.shift[`ADDR_SELECT_MSB:`ADDR_SELECT_LSB] == ADDR_SELECT); // RULE7
	end

	// ****************************************
	// link state machine
	// ****************************************
	always_comb begin
		next_r = r;
		next_r.pins_s1 = '{scl: scl_in, sda: sda_in};
		next_r.pins_s2 = r.pins_s1;
		next_r.pins_d = r.pins_s2;
		next_r.done_s1 = core_done_tgl;
		next_r.done_s2 = r.done_s1;
		next_r.done_d = r.done_s2;
		if (r.done_s2 != r.done_d) begin
			next_r.latest = core_result; // RULE22
		end
		if (start_seen) begin
			next_r.state = LINK_ADDR;
			next_r.bit_count = 4'h0;
			next_r.sda_oen = 1'b1;
		end else if (stop_seen) begin
			next_r.state = LINK_IGNORE;
			next_r.sda_oen = 1'b1;
		end else begin
			unique case (r.state)
				LINK_IGNORE: begin
					next_r.sda_oen = 1'b1; // RULE25
				end
				LINK_ADDR: begin
					if (scl_rise) begin
						next_r.shift = {r.shift[6:0], r.pins_s2.sda}; // RULE3
						next_r.bit_count = r.bit_count + 4'h1;
					end
					if (scl_fall && (r.bit_count == `BITS_PER_BYTE)) begin
						if (addr_match) begin
							next_r.sda_oen = 1'b0; // RULE12
							next_r.dir_read = (r.shift[`DIR_BIT] == `DIR_READ); // RULE9
							if (r.shift[`DIR_BIT] == `DIR_READ) begin
								next_r.conv_tgl = ~r.conv_tgl; // RULE11
							end
							next_r.state = LINK_ADDR_ACK; // RULE5
						end else begin
							next_r.state = LINK_IGNORE; // RULE25
						end
					end
				end
				LINK_ADDR_ACK: begin
					if (scl_fall) begin
						if (r.dir_read) begin
							next_r.held = r.latest;
							next_r.shift = high_byte(r.latest);
							next_r.sda_oen = high_byte(r.latest) >> 7 != 8'h00; // RULE23
							next_r.low_byte = 1'b0;
							next_r.bit_count = 4'h0;
							next_r.state = LINK_TX;
						end else begin
							next_r.sda_oen = 1'b1; // RULE10
							next_r.state = LINK_IGNORE;
						end
					end
				end
				LINK_TX: begin
					if (scl_fall) begin
						next_r.bit_count = r.bit_count + 4'h1;
						if (r.bit_count == `BITS_PER_BYTE - 4'h1) begin
							next_r.sda_oen = 1'b1;
							next_r.state = LINK_TX_ACK;
							if (r.low_byte) begin
								next_r.conv_tgl = ~r.conv_tgl; // RULE18
							end
						end else begin
							next_r.shift = {r.shift[6:0], 1'b0};
							next_r.sda_oen = r.shift[6]; // RULE23
						end
					end
				end
				LINK_TX_ACK: begin
					if (scl_rise) begin
						next_r.master_ack = ~r.pins_s2.sda;
					end
					if (scl_fall) begin
						next_r.bit_count = 4'h0;
						if (r.master_ack) begin
							next_r.state = LINK_TX; // RULE19
							if (r.low_byte) begin
								next_r.held = r.latest; // RULE21
								next_r.shift = high_byte(r.latest);
								next_r.sda_oen = high_byte(r.latest) >> 7 != 8'h00;
								next_r.low_byte = 1'b0;
							end else begin
								next_r.shift = low_byte_of(r.held);
								next_r.sda_oen = r.held[5];
								next_r.low_byte = 1'b1;
							end
						end else begin
							next_r.sda_oen = 1'b1; // RULE6
							next_r.state = LINK_IGNORE;
						end
					end
				end
				default: begin
					next_r.state = LINK_IGNORE;
					next_r.sda_oen = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk_in or negedge link_rstn) begin
		if (!link_rstn) begin
			r <= '{
				pins_s1: '{scl: 1'b1, sda: 1'b1},
				pins_s2: '{scl: 1'b1, sda: 1'b1},
				pins_d: '{scl: 1'b1, sda: 1'b1},
				state: LINK_IGNORE,
				sda_oen: 1'b1,
				default: '0
			};
		end else begin
			r <= next_r;
		end
	end

	// ****************************************
	// open-drain data pin
	// ****************************************
	assign sda_out = 1'b0;
	assign sda_oen_out = r.sda_oen; // RULE5

endmodule
`default_nettype wire

// >>> adc_i2c_read_slave_asserts.sv
// port checks of the serial read slave
`timescale 1ns/1ps
`default_nettype none

module adc_i2c_read_slave_asserts #(
	parameter int RESULT_W = 10
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic link_clk_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oen_out,
	input wire logic [RESULT_W-1:0] analog_input_pin_in,
	input wire logic [RESULT_W-1:0] result_out,
	input wire logic busy_out
);
	// ********
	// helper counters
	// ********
	logic [15:0] busy_cnt;
	logic [7:0] since_fall;
	logic started;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) busy_cnt <= 16'h0;
		else busy_cnt <= busy_out ? busy_cnt + 16'h1 : 16'h0;
	end
	always_ff @(posedge link_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			since_fall <= 8'hff;
			started <= 1'b0;
		end else begin
			since_fall <= $fell(scl_in) ? 8'h0 : since_fall + {7'h0, since_fall != 8'hff};
			started <= started | (scl_in && $fell(sda_in));
		end
	end
	sequence stop_seen;
		scl_in && $rose(sda_in);
	endsequence
	sequence conv_end;
		$fell(busy_out);
	endsequence
	// ********
	// assertions
	// ********
	a_drive_zero: assert property (@(posedge link_clk_in) disable iff (!rstn_in)
		sda_out == 1'b0) else $error("sda_out not low");
	a_quiet_start: assert property (@(posedge link_clk_in) disable iff (!rstn_in)
		!started |-> sda_oen_out) else $error("drive before start");
	a_high_steady: assert property (@(posedge link_clk_in) disable iff (!rstn_in)
		scl_in && $past(scl_in) |-> $stable(sda_oen_out)) else $error("change in high");
	a_after_fall: assert property (@(posedge link_clk_in) disable iff (!rstn_in)
		$changed(sda_oen_out) |-> since_fall <= 8'h8) else $error("late change");
	a_low_holds: assert property (@(posedge link_clk_in) disable iff (!rstn_in)
		!sda_oen_out && $rose(scl_in) |-> !sda_oen_out[*8]) else $error("low not held");
	a_stop_free: assert property (@(posedge link_clk_in) disable iff (!rstn_in)
		stop_seen |-> sda_oen_out[*8]) else $error("drive after stop");
	a_conv_span: assert property (@(posedge clk_in) disable iff (!rstn_in)
		conv_end |-> busy_cnt == 16'h195) else $error("bad conversion length");
	a_result_value: assert property (@(posedge clk_in) disable iff (!rstn_in)
		conv_end |-> result_out == analog_input_pin_in) else $error("bad result");
endmodule

bind adc_i2c_read_slave adc_i2c_read_slave_asserts #(.RESULT_W(RESULT_W)) i_asserts (
	.clk_in(clk_in),
	.rstn_in(rstn_in),
	.link_clk_in(link_clk_in),
	.scl_in(scl_in),
	.sda_in(sda_in),
	.sda_out(sda_out),
	.sda_oen_out(sda_oen_out),
	.analog_input_pin_in(analog_input_pin_in),
	.result_out(result_out),
	.busy_out(busy_out)
);
`default_nettype wire

// >>> i2c_master_model.sv
// two-wire bus master model
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_low_out
);
	// ********
	// bus conditions and bits
	// ********
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	task automatic quarter;
		repeat (12) @(negedge clk_in);
	endtask
	task automatic start_cond;
		quarter();
		sda_low_out = 1'b1;
		quarter();
		scl_out = 1'b0;
		quarter();
	endtask
	task automatic stop_cond;
		sda_low_out = 1'b1;
		quarter();
		scl_out = 1'b1;
		quarter();
		sda_low_out = 1'b0;
		quarter();
	endtask
	task automatic xfer_bit(input logic b, output logic r);
		sda_low_out = !b;
		quarter();
		scl_out = 1'b1;
		quarter();
		r = sda_in;
		quarter();
		scl_out = 1'b0;
		quarter();
	endtask
	task automatic xfer_byte(input logic [7:0] d, input logic ack, output logic [7:0] r,
		output logic ack_seen);
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(d[i], r[i]);
		end
		xfer_bit(ack, ack_seen);
	endtask
endmodule
`default_nettype wire

// >>> adc_i2c_read_slave_tb.sv
// self-checking bench of the serial read slave
`timescale 1ns/1ps
`default_nettype none

module adc_i2c_read_slave_tb;
	typedef struct packed {
		logic [7:0] addr;
		logic ack;
		logic busy;
		logic [7:0] data;
	} row_t;
	logic clk_in;
	logic rstn_in;
	logic link_clk;
	logic scl;
	logic sda_low;
	logic sda_oen;
	logic sda_wire;
	logic sda_drv;
	logic [9:0] analog_input_pin;
	logic [9:0] result;
	logic busy;
	int failures = 0;
	int n_tests = 0;
	row_t rows [5] = '{'{8'h6a, 1'b0, 1'b0, 8'hff}, '{8'h6b, 1'b0, 1'b1, 8'h00},
		'{8'h69, 1'b1, 1'b0, 8'hff}, '{8'h3b, 1'b1, 1'b0, 8'hff}, '{8'h6e, 1'b1, 1'b0, 8'hff}};
	assign sda_wire = !sda_low && (sda_oen || sda_drv);
	adc_i2c_read_slave #(.DEVICE_CODE(4'h6), .ADDR_SELECT(3'h5), .RESULT_W(10))
		i_adc_i2c_read_slave (.clk_in(clk_in), .rstn_in(rstn_in), .link_clk_in(link_clk),
		.scl_in(scl), .sda_in(sda_wire), .sda_out(sda_drv), .sda_oen_out(sda_oen),
		.analog_input_pin_in(analog_input_pin), .result_out(result), .busy_out(busy));
	i2c_master_model i_i2c_master_model (.clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl),
		.sda_low_out(sda_low));
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #16 link_clk = ~link_clk;
	end
	// ********
	// checks and transfers
	// ********
	task automatic chk_val(input string what, input logic [9:0] exp, input logic [9:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		chk_val(what, {9'h0, exp}, {9'h0, got});
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic address(input logic [7:0] addr, output logic ack);
		logic [7:0] d;
		i_i2c_master_model.start_cond();
		i_i2c_master_model.xfer_byte(addr, 1'b1, d, ack);
	endtask
	task automatic read_pair(input logic nak, input logic [9:0] exp);
		logic [7:0] b0;
		logic [7:0] b1;
		logic a;
		i_i2c_master_model.xfer_byte(8'hff, 1'b0, b0, a);
		i_i2c_master_model.xfer_byte(8'hff, nak, b1, a);
		chk_val("high byte", {6'h0, exp[9:6]}, {2'h0, b0});
		chk_val("low byte", {2'h0, exp[5:0], 2'h0}, {2'h0, b1[7:2], 2'h0});
	endtask
	task automatic conv_wait;
		i_i2c_master_model.stop_cond();
		repeat (480) @(negedge clk_in);
	endtask
	initial begin
		repeat (40000) @(posedge clk_in);
		failures++;
		test_done();
	end
	initial begin
		logic [7:0] d;
		logic a;
		rstn_in = 1'b0;
		analog_input_pin = 10'h155;
		repeat (9) @(negedge clk_in);
		chk_bit("reset release", 1'b1, sda_oen);
		chk_val("reset result", 10'h0, result);
		rstn_in = 1'b1;
		repeat (40) @(negedge clk_in);
		foreach (rows[i]) begin
			address(rows[i].addr, a);
			chk_bit("address ack", rows[i].ack, a);
			chk_bit("busy", rows[i].busy, busy);
			i_i2c_master_model.xfer_byte(8'hff, 1'b1, d, a);
			chk_val("tail byte", {2'h0, rows[i].data}, {2'h0, d});
			chk_bit("tail ack", 1'b1, a);
			conv_wait();
		end
		chk_val("converted", 10'h155, result);
		analog_input_pin = 10'h2c5;
		address(8'h6b, a);
		read_pair(1'b1, 10'h155);
		conv_wait();
		chk_val("converted", 10'h2c5, result);
		analog_input_pin = 10'h0ea;
		address(8'h6b, a);
		read_pair(1'b0, 10'h2c5);
		read_pair(1'b0, 10'h0ea);
		read_pair(1'b1, 10'h0ea);
		conv_wait();
		chk_val("converted", 10'h0ea, result);
		rstn_in = 1'b0;
		@(negedge clk_in);
		chk_val("reset result", 10'h0, result);
		chk_bit("reset busy", 1'b0, busy);
		test_done();
	end
endmodule
`default_nettype wire
